// ### common/fpm_pkg.sv
// Shared constants and types for flash protection and memory select
package fpm_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 16;
  localparam int DATA_W   = 8;
  localparam int NUM_MAIN = 8;
  localparam int NUM_BOOT = 4;
  localparam int NUM_SEC  = NUM_MAIN + NUM_BOOT;
  localparam int CNT_W    = 12;
  // ----------------------------------------------------------------
  // Flash command sequences
  // ----------------------------------------------------------------
  localparam logic [11:0] UNLK1_ADDR   = 12'hAAA;
  localparam logic [7:0]  UNLK1_DATA   = 8'hAA;
  localparam logic [11:0] UNLK2_ADDR   = 12'h554;
  localparam logic [7:0]  UNLK2_DATA   = 8'h55;
  localparam logic [7:0]  CMD_RESET    = 8'hF0;
  localparam logic [7:0]  CMD_PROG     = 8'hA0;
  localparam logic [7:0]  CMD_ERASE    = 8'h80;
  localparam logic [7:0]  CMD_BULK     = 8'h10;
  localparam logic [7:0]  CMD_SECTOR   = 8'h30;
  localparam logic [7:0]  CMD_PROT_RD  = 8'h90;
  localparam logic [7:0]  ERASED_WORD  = 8'hFF;
  localparam int          STAT_ERR_BIT = 5;
  localparam int          STAT_BSY_BIT = 6;
  // ----------------------------------------------------------------
  // Configuration register space offsets and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MAIN_PROT = 8'hC0;
  localparam logic [7:0] OFS_BOOT_PROT = 8'hC2;
  localparam logic [7:0] OFS_SPACE_MAP = 8'hC4;
  localparam int         BOOT_SEC_BIT  = 7;
  localparam int MAP_PIO       = 7;
  localparam int MAP_MAIN_DATA = 4;
  localparam int MAP_BOOT_DATA = 3;
  localparam int MAP_MAIN_CODE = 2;
  localparam int MAP_BOOT_CODE = 1;
  localparam int MAP_SRAM_CODE = 0;
  localparam logic [7:0] MAP_SEPARATE = 8'h0C;
  localparam logic [7:0] MAP_RSVD     = 8'h60;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ      = 100;
  localparam int RST_WAIT_US  = 25;
  localparam int RST_WAIT_CYC = RST_WAIT_US * CLK_MHZ;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_READ  = 2'b00,
    OP_FETCH = 2'b01,
    OP_WRITE = 2'b10
  } fpm_op_e;

  typedef enum logic [3:0] {
    FS_IDLE = 4'b0000, FS_U1   = 4'b0001, FS_U2   = 4'b0010,
    FS_ARM  = 4'b0011, FS_E0   = 4'b0100, FS_E1   = 4'b0101,
    FS_E2   = 4'b0110, FS_PROG = 4'b0111, FS_BULK = 4'b1000,
    FS_SECT = 4'b1001, FS_ERR  = 4'b1010, FS_RSTW = 4'b1011,
    FS_PROT = 4'b1100
  } fpm_fstate_e;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00, HS_STROBE = 2'b01, HS_WAIT = 2'b10, HS_RST = 2'b11
  } fpm_hstate_e;
endpackage : fpm_pkg

// ### common/fpm_bus_if.sv
// Host bus between microcontroller end and memory device end
`timescale 1ns/10ps
interface fpm_bus_if;
  import fpm_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic              fetch;
  logic              ext_reset;
  logic [DATA_W-1:0] rdata;
  logic              ack;
  logic              drive;
  logic              busy;

  modport dev (
    input  addr, wdata, wr, rd, fetch, ext_reset,
    output rdata, ack, drive, busy
  );
  modport host (
    output addr, wdata, wr, rd, fetch, ext_reset,
    input  rdata, ack, drive, busy
  );
endinterface : fpm_bus_if

// ### core/fpm_device.sv
// Flash protection, flash command engine and memory select device end
`timescale 1ns/10ps
// What this block does
// - Each main and boot sector has protection
// - Protection readable, changed only by programming path
// - Program or erase on protected sector discarded
// - Verify read returns protected sector data
// - Protection readable by registers and command
// - Main status bit i is sector i
// - Boot status bits 3..0 are boot sectors
// - Boot status bit 7 shows security lock
// - Reset command single or after unlock
// - Host resets after status reads and errors
// - Reset immediate, or 25 us after error
// - Reset ignored during program or bulk erase
// - Reset aborts sector erase within 25 us
// - Reset pin aborts operation, up to 25 us
// - Host holds reset pin at least 25 us
// - SRAM answers only while selected
// - All selects come from decode array
// - Boot sector wins over main sector
// - SRAM and config win over flash; peripheral I/O only while enabled in the space map
// - Same-level selects never overlap
// - Space map gates strobes per memory
// - Space map resets separate, host rewritable
module fpm_device
  import fpm_pkg::*;
#(
  parameter int              WORD_AW     = 2,
  parameter int              SRAM_AW     = 3,
  parameter int              PROG_CYC    = 20,
  parameter int              ERASE_CYC   = 200,
  parameter int              SEC_SHIFT   = 12,
  parameter logic [15:0]     MAIN_ORIGIN = 16'h8000,
  parameter logic [15:0]     BOOT_ORIGIN = 16'h0000,
  parameter logic [15:0]     SRAM_BASE   = 16'h7000,
  parameter logic [15:0]     SRAM_MASK   = 16'hF800,
  parameter logic [15:0]     CFG_BASE    = 16'h7800,
  parameter logic [15:0]     CFG_MASK    = 16'hFF00,
  parameter logic [15:0]     PIO_BASE    = 16'h7900,
  parameter logic [15:0]     PIO_MASK    = 16'hFF00,
  parameter logic [7:0]      MAP_INIT    = MAP_SEPARATE
) (
  input  wire logic          clk,
  input  wire logic          sys_rst,
  fpm_bus_if.dev             bus,
  input  wire logic          prog_we,
  input  wire logic [7:0]    prog_main_prot,
  input  wire logic [3:0]    prog_boot_prot,
  input  wire logic          prog_secure,
  input  wire logic [7:0]    pio_rdata,
  output logic               pio_rd,
  output logic               pio_wr,
  output logic [7:0]         pio_wdata,
  output logic [7:0]         space_map
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int WPS   = 1 << WORD_AW;
  localparam int SWRDS = 1 << SRAM_AW;

  typedef struct packed {
    logic                sram;
    logic                cfg;
    logic                pio;
    logic                flash;
    logic [3:0]          sec;
  } fpm_hit_s;

  typedef struct packed {
    fpm_fstate_e                        fst;
    logic [CNT_W-1:0]                   cnt;
    logic                               err;
    logic [3:0]                         tsec;
    logic [WORD_AW-1:0]                 tword;
    logic [7:0]                         tdata;
    logic [NUM_SEC-1:0]                 emask;
    logic [NUM_MAIN-1:0]                main_prot;
    logic [NUM_BOOT-1:0]                boot_prot;
    logic                               secure;
    logic [7:0]                         map;
    logic [NUM_SEC-1:0][WPS-1:0][7:0]   mem;
    logic [SWRDS-1:0][7:0]              sram;
    logic [7:0]                         rdata;
    logic                               ack;
    logic                               drive;
    logic                               busy;
    logic                               pio_rd;
    logic                               pio_wr;
    logic [7:0]                         pio_wdata;
  } fpm_dev_s;

  fpm_dev_s q;
  fpm_dev_s next_q;

  // ----------------------------------------------------------------
  // Address decode array with priority and space gating
  // ----------------------------------------------------------------
  function automatic fpm_hit_s decode(input logic [15:0] a,
                                      input logic [7:0]  m,
                                      input logic        code);
    fpm_hit_s    h;
    logic        mhit;
    logic        bhit;
    logic [3:0]  msec;
    logic [3:0]  bsec;
    logic [15:0] sa;
    h    = '0;
    mhit = 1'b0;
    bhit = 1'b0;
    msec = '0;
    bsec = '0;
    sa   = a >> SEC_SHIFT;
    for (int i = 0; i < NUM_MAIN; i++) begin
      if (sa == (MAIN_ORIGIN >> SEC_SHIFT) + 16'(i)) begin
        mhit = 1'b1;
        msec = 4'(i);
      end
    end
    for (int i = 0; i < NUM_BOOT; i++) begin
      if (sa == (BOOT_ORIGIN >> SEC_SHIFT) + 16'(i)) begin
        bhit = 1'b1;
        bsec = 4'(NUM_MAIN + i);
      end
    end
    // A gated SRAM or config level still hides the flash below it; PIO switched off in the map does not
    if ((a & SRAM_MASK) == SRAM_BASE) begin
      h.sram = code ? m[MAP_SRAM_CODE] : 1'b1;
    end else if ((a & CFG_MASK) == CFG_BASE) begin
      h.cfg = ~code;
    end else if ((a & PIO_MASK) == PIO_BASE && m[MAP_PIO]) begin
      h.pio = ~code;
    end else if (bhit) begin
      h.flash = code ? m[MAP_BOOT_CODE] : m[MAP_BOOT_DATA];
      h.sec   = bsec;
    end else if (mhit) begin
      h.flash = code ? m[MAP_MAIN_CODE] : m[MAP_MAIN_DATA];
      h.sec   = msec;
    end
    return h;
  endfunction : decode

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  fpm_hit_s           h;
  logic [NUM_SEC-1:0] prot;
  logic [7:0]         d;
  logic [11:0]        a12;
  logic               fwr;
  logic               is_rst;

  always_comb begin
    next_q        = q;
    next_q.ack    = 1'b0;
    next_q.drive  = 1'b0;
    next_q.pio_rd = 1'b0;
    next_q.pio_wr = 1'b0;
    h      = decode(bus.addr, q.map, bus.fetch);
    prot   = {q.boot_prot, q.main_prot};
    d      = bus.wdata;
    a12    = bus.addr[11:0];
    fwr    = bus.wr && h.flash;
    is_rst = fwr && d == CMD_RESET;
    if (prog_we) begin
      next_q.main_prot = prog_main_prot;
      next_q.boot_prot = prog_boot_prot;
      next_q.secure    = prog_secure;
    end
    // Stale read data never rides on a write ack
    if (bus.rd || bus.fetch || bus.wr) begin
      next_q.ack   = 1'b1;
      next_q.rdata = '0;
    end
    // Reads: only a selected, ungated target drives the bus
    if (bus.rd || bus.fetch) begin
      next_q.drive = h.sram | h.cfg | h.pio | h.flash;
      next_q.rdata = '0;
      if (h.sram) begin
        next_q.rdata = q.sram[bus.addr[SRAM_AW-1:0]];
      end else if (h.cfg) begin
        unique case (bus.addr[7:0])
          OFS_MAIN_PROT: next_q.rdata = q.main_prot;
          OFS_BOOT_PROT: begin
            next_q.rdata[NUM_BOOT-1:0] = q.boot_prot;
            next_q.rdata[BOOT_SEC_BIT] = q.secure;
          end
          OFS_SPACE_MAP: next_q.rdata = q.map;
          default:       next_q.rdata = '0;
        endcase
      end else if (h.pio) begin
        next_q.pio_rd = 1'b1;
        next_q.rdata  = pio_rdata;
      end else if (h.flash) begin
        if (q.fst == FS_PROT) begin
          next_q.rdata = {7'h00, prot[h.sec]};
        end else if (q.busy) begin
          next_q.rdata[STAT_ERR_BIT] = q.err;
          next_q.rdata[STAT_BSY_BIT] = 1'b1;
        end else begin
          next_q.rdata = q.mem[h.sec][bus.addr[WORD_AW-1:0]];
        end
      end
    end
    // Writes to SRAM, config space and peripheral I/O
    if (bus.wr && h.sram) begin
      next_q.sram[bus.addr[SRAM_AW-1:0]] = d;
    end
    if (bus.wr && h.cfg && bus.addr[7:0] == OFS_SPACE_MAP) begin
      next_q.map = d & ~MAP_RSVD;
    end
    if (bus.wr && h.pio) begin
      next_q.pio_wr    = 1'b1;
      next_q.pio_wdata = d;
    end
    // Flash command engine
    unique case (q.fst)
      FS_IDLE, FS_PROT: begin
        if (is_rst) begin
          next_q.fst = FS_IDLE;
        end else if (fwr && a12 == UNLK1_ADDR && d == UNLK1_DATA) begin
          next_q.fst = FS_U1;
        end
      end
      FS_U1: begin
        if (fwr) begin
          next_q.fst = (a12 == UNLK2_ADDR && d == UNLK2_DATA) ? FS_U2
                                                             : FS_IDLE;
        end
      end
      FS_U2: begin
        if (fwr) begin
          unique case (d)
            CMD_PROG:    next_q.fst = FS_ARM;
            CMD_ERASE:   next_q.fst = FS_E0;
            CMD_PROT_RD: next_q.fst = FS_PROT;
            default:     next_q.fst = FS_IDLE;
          endcase
        end
      end
      FS_ARM: begin
        if (fwr) begin
          next_q.tsec  = h.sec;
          next_q.tword = bus.addr[WORD_AW-1:0];
          next_q.tdata = d;
          next_q.cnt   = '0;
          next_q.err   = |(d & ~q.mem[h.sec][bus.addr[WORD_AW-1:0]]);
          next_q.fst   = prot[h.sec] ? FS_IDLE : FS_PROG;
        end
      end
      FS_E0: begin
        if (fwr) begin
          next_q.fst = (a12 == UNLK1_ADDR && d == UNLK1_DATA) ? FS_E1
                                                             : FS_IDLE;
        end
      end
      FS_E1: begin
        if (fwr) begin
          next_q.fst = (a12 == UNLK2_ADDR && d == UNLK2_DATA) ? FS_E2
                                                             : FS_IDLE;
        end
      end
      FS_E2: begin
        if (fwr) begin
          next_q.cnt = '0;
          next_q.fst = FS_IDLE;
          if (d == CMD_BULK) begin
            next_q.emask = ~prot;
            next_q.fst   = FS_BULK;
          end else if (d == CMD_SECTOR && !prot[h.sec]) begin
            next_q.emask        = '0;
            next_q.emask[h.sec] = 1'b1;
            next_q.fst          = FS_SECT;
          end
        end
      end
      FS_PROG: begin
        next_q.cnt = q.cnt + 1'b1;
        if (q.cnt == CNT_W'(PROG_CYC - 1)) begin
          next_q.mem[q.tsec][q.tword] = q.mem[q.tsec][q.tword] & q.tdata;
          next_q.fst = q.err ? FS_ERR : FS_IDLE;
        end
      end
      FS_BULK, FS_SECT: begin
        next_q.cnt = q.cnt + 1'b1;
        if (q.fst == FS_SECT && is_rst) begin
          next_q.cnt = '0;
          next_q.fst = FS_RSTW;
        end else if (q.cnt == CNT_W'(ERASE_CYC - 1)) begin
          for (int s = 0; s < NUM_SEC; s++) begin
            if (q.emask[s]) begin
              next_q.mem[s] = {WPS{ERASED_WORD}};
            end
          end
          next_q.fst = FS_IDLE;
        end
      end
      FS_ERR: begin
        if (is_rst) begin
          next_q.cnt = '0;
          next_q.fst = FS_RSTW;
        end
      end
      FS_RSTW: begin
        next_q.cnt = q.cnt + 1'b1;
        if (q.cnt == CNT_W'(RST_WAIT_CYC - 1)) begin
          next_q.err = 1'b0;
          next_q.fst = FS_IDLE;
        end
      end
      default: next_q.fst = FS_IDLE;
    endcase
    // Pin reset outranks everything; a busy flash settles first
    if (bus.ext_reset) begin
      next_q.cnt = '0;
      if (q.busy) begin
        next_q.fst = FS_RSTW;
      end else begin
        next_q.fst = FS_IDLE;
      end
    end
    next_q.busy = next_q.fst inside {FS_PROG, FS_BULK, FS_SECT,
                                     FS_ERR, FS_RSTW};
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q     <= '0;
      q.fst <= FS_IDLE;
      q.map <= MAP_INIT;
      q.mem <= '1;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bus.rdata = q.rdata;
  assign bus.ack   = q.ack;
  assign bus.drive = q.drive;
  assign bus.busy  = q.busy;
  assign pio_rd    = q.pio_rd;
  assign pio_wr    = q.pio_wr;
  assign pio_wdata = q.pio_wdata;
  assign space_map = q.map;
endmodule : fpm_device

// ### core/fpm_host.sv
// Microcontroller end: runs one bus access at a time, drives reset pin
`timescale 1ns/10ps
module fpm_host
  import fpm_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  fpm_bus_if.host                bus,
  input  wire logic              req,
  input  wire fpm_op_e           req_op,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic              pin_rst_req,
  output logic                   ready,
  output logic                   done,
  output logic [DATA_W-1:0]      rsp_data,
  output logic                   rsp_driven,
  output logic                   dev_busy
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    fpm_hstate_e        st;
    logic [CNT_W-1:0]   cnt;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  wdata;
    logic               wr;
    logic               rd;
    logic               fetch;
    logic               ext_reset;
    logic               ready;
    logic               done;
    logic [DATA_W-1:0]  rsp_data;
    logic               rsp_driven;
    logic               dev_busy;
  } fpm_host_s;

  fpm_host_s q;
  fpm_host_s next_q;

  always_comb begin
    next_q          = q;
    next_q.done     = 1'b0;
    next_q.wr       = 1'b0;
    next_q.rd       = 1'b0;
    next_q.fetch    = 1'b0;
    next_q.dev_busy = bus.busy;
    unique case (q.st)
      HS_IDLE: begin
        if (pin_rst_req) begin
          next_q.cnt       = '0;
          next_q.ext_reset = 1'b1;
          next_q.st        = HS_RST;
        end else if (req) begin
          next_q.addr  = req_addr;
          next_q.wdata = req_wdata;
          next_q.rd    = req_op == OP_READ;
          next_q.fetch = req_op == OP_FETCH;
          next_q.wr    = req_op == OP_WRITE;
          next_q.st    = HS_STROBE;
        end
      end
      HS_STROBE: next_q.st = HS_WAIT;
      HS_WAIT: begin
        if (bus.ack) begin
          next_q.done       = 1'b1;
          next_q.rsp_data   = bus.drive ? bus.rdata : '0;
          next_q.rsp_driven = bus.drive;
          next_q.st         = HS_IDLE;
        end
      end
      HS_RST: begin
        // Held 25 us; a flash busy at assertion needs 25 us more after release
        next_q.cnt = q.cnt + 1'b1;
        if (q.cnt == CNT_W'(RST_WAIT_CYC - 1)) begin
          next_q.ext_reset = 1'b0;
          next_q.st        = HS_IDLE;
        end
      end
      default: next_q.st = HS_IDLE;
    endcase
    next_q.ready = next_q.st == HS_IDLE;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q       <= '0;
      q.st    <= HS_IDLE;
      q.ready <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bus.addr      = q.addr;
  assign bus.wdata     = q.wdata;
  assign bus.wr        = q.wr;
  assign bus.rd        = q.rd;
  assign bus.fetch     = q.fetch;
  assign bus.ext_reset = q.ext_reset;
  assign ready         = q.ready;
  assign done          = q.done;
  assign rsp_data      = q.rsp_data;
  assign rsp_driven    = q.rsp_driven;
  assign dev_busy      = q.dev_busy;
endmodule : fpm_host

// ### testbench/fpm_bus_asserts.sv
// Concurrent checks on the host bus between the two ends
`timescale 1ns/10ps
module fpm_bus_asserts
  import fpm_pkg::*;
(
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic              fetch,
  input wire logic              ext_reset,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              ack,
  input wire logic              drive,
  input wire logic              busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ------
  // Checks
  // ------
  ack_timing_a:
    assert property ((rd | fetch | wr) |=> ack)
    else $error("Strobe not acked next cycle");
  ack_cause_a:
    assert property (ack |-> $past(rd | fetch | wr))
    else $error("Ack without strobe");
  write_undriven_a:
    assert property (wr |=> !drive)
    else $error("Bus driven on write");
  idle_bus_zero_a:
    assert property (ack && !drive |-> rdata == 8'h00)
    else $error("Undriven read not zero");
  drive_in_ack_a:
    assert property (drive |-> ack)
    else $error("Drive outside ack");
  map_rsvd_zero_a:
    assert property (rd && addr == 16'h78c4 |=> drive && rdata[6:5] == 2'b00)
    else $error("Map reserved bits set");
  boot_unused_zero_a:
    assert property (rd && addr == 16'h78c2 |=> drive && rdata[6:4] == 3'h0)
    else $error("Boot status unused bits set");
  sram_data_a:
    assert property (rd && addr[15:11] == 5'b01110 |=> drive)
    else $error("Data read of SRAM not driven");
  pin_hold_a:
    assert property ($rose(ext_reset) |-> ext_reset [*8])
    else $error("Reset pin pulse too short");
  cover property (fetch ##1 drive);
  cover property ($rose(busy));
  cover property ($rose(ext_reset));
  cover property (ack && !drive);
endmodule : fpm_bus_asserts

// ### testbench/tb_top.sv
// Self-checking bench: host end and device end joined by the bus
`timescale 1ns/10ps
module tb_top;
  import fpm_pkg::*;
  logic              clk;
  logic              sys_rst;
  logic              req;
  fpm_op_e           req_op;
  logic [15:0]       req_addr;
  logic [7:0]        req_wdata;
  logic              pin_rst_req;
  logic              ready;
  logic              done;
  logic [7:0]        rsp_data;
  logic              rsp_driven;
  logic              dev_busy;
  logic              prog_we;
  logic [7:0]        prog_main_prot;
  logic [3:0]        prog_boot_prot;
  logic              prog_secure;
  logic [7:0]        pio_rdata;
  logic [7:0]        pio_wdata;
  logic [7:0]        space_map;
  integer            seed;
  integer            mismatches;
  integer            n_tests;
  logic [7:0]        pm;
  logic [3:0]        pb;
  logic [7:0]        d;
  logic [7:0]        m;
  logic [7:0]        got;
  logic              drv;
  fpm_op_e           ops [6] = '{OP_READ, OP_FETCH, OP_READ, OP_FETCH,
                                 OP_FETCH, OP_READ};
  logic [15:0]       adrs [6] = '{16'h8000, 16'h8000, 16'h0000, 16'h0000,
                                  16'h7000, 16'h7900};

  fpm_bus_if fpm_bus_if_inst ();
  fpm_device #(.PROG_CYC(4), .ERASE_CYC(8)) fpm_device_inst (
    .clk(clk), .sys_rst(sys_rst), .bus(fpm_bus_if_inst.dev),
    .prog_we(prog_we), .prog_main_prot(prog_main_prot),
    .prog_boot_prot(prog_boot_prot), .prog_secure(prog_secure),
    .pio_rdata(pio_rdata), .pio_rd(), .pio_wr(), .pio_wdata(pio_wdata),
    .space_map(space_map));
  fpm_host fpm_host_inst (
    .clk(clk), .sys_rst(sys_rst), .bus(fpm_bus_if_inst.host), .req(req),
    .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
    .pin_rst_req(pin_rst_req), .ready(ready), .done(done),
    .rsp_data(rsp_data), .rsp_driven(rsp_driven), .dev_busy(dev_busy));
  fpm_bus_asserts fpm_bus_asserts_inst (
    .clk(clk), .sys_rst(sys_rst), .addr(fpm_bus_if_inst.addr),
    .wr(fpm_bus_if_inst.wr), .rd(fpm_bus_if_inst.rd),
    .fetch(fpm_bus_if_inst.fetch), .ext_reset(fpm_bus_if_inst.ext_reset),
    .rdata(fpm_bus_if_inst.rdata), .ack(fpm_bus_if_inst.ack),
    .drive(fpm_bus_if_inst.drive), .busy(fpm_bus_if_inst.busy));

  // -----------
  // Bench tasks
  // -----------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests = n_tests + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // One host access; waits for done under a bound
  task automatic acc(input fpm_op_e op, input logic [15:0] a,
                     input logic [7:0] wd);
    int k;
    @(posedge clk);
    req <= 1'b1;
    req_op <= op;
    req_addr <= a;
    req_wdata <= wd;
    @(posedge clk);
    req <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (done !== 1'b1 && k < 20);
    chk({7'h0, done}, 8'h01);
    got = rsp_data;
    drv = rsp_driven;
  endtask : acc

  task automatic cmd(input logic [7:0] c);
    acc(OP_WRITE, 16'h0aaa, 8'haa);
    acc(OP_WRITE, 16'h0554, 8'h55);
    acc(OP_WRITE, 16'h0aaa, c);
  endtask : cmd

  // Data strobes to SRAM always pass; PIO only in its mode
  function automatic logic exp_drv(input fpm_op_e op, input logic [15:0] a,
                                   input logic [7:0] mp);
    if (a[15]) return (op == OP_FETCH) ? mp[2] : mp[4];
    if (a[11:8] == 4'h9) return mp[7];
    if (a[14:12] == 3'h7) return (op == OP_FETCH) ? mp[0] : 1'b1;
    return (op == OP_FETCH) ? mp[1] : mp[3];
  endfunction : exp_drv

  task automatic conclude();
    if (mismatches == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Whole run is near 8000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches = mismatches + 1;
    conclude();
  end

  // ---------
  // Scenarios
  // ---------
  initial begin
    {req, pin_rst_req, prog_we, prog_secure} = 4'h0;
    req_op = OP_READ;
    {req_addr, req_wdata, prog_main_prot, prog_boot_prot} = '0;
    seed = 32'h6cf9_9c7c;
    pio_rdata = 8'($random(seed));
    mismatches = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    acc(OP_READ, 16'h78c4, 8'h00);
    chk(got, MAP_SEPARATE);
    acc(OP_READ, 16'h78c0, 8'h00);
    chk(got, 8'h00);
    pm = 8'($random(seed));
    pb = {2'($random(seed)), 2'b10};
    @(posedge clk);
    prog_we <= 1'b1;
    prog_main_prot <= pm;
    prog_boot_prot <= pb;
    prog_secure <= 1'b1;
    @(posedge clk);
    prog_we <= 1'b0;
    acc(OP_WRITE, 16'h78c0, ~pm);
    acc(OP_READ, 16'h78c0, 8'h00);
    chk(got, pm);
    acc(OP_READ, 16'h78c2, 8'h00);
    chk(got, {4'h8, pb});
    d = 8'($random(seed)) & 8'hfe;
    cmd(CMD_PROG);
    acc(OP_WRITE, 16'h1000, 8'h00);
    cmd(CMD_PROG);
    acc(OP_WRITE, 16'h0002, d);
    repeat (10) @(posedge clk);
    acc(OP_READ, 16'h1000, 8'h00);
    chk(got, ERASED_WORD);
    acc(OP_READ, 16'h0002, 8'h00);
    chk(got, d);
    cmd(CMD_PROG);
    acc(OP_WRITE, 16'h0002, 8'hff);
    repeat (10) @(posedge clk);
    acc(OP_READ, 16'h0002, 8'h00);
    chk({7'h0, got[STAT_ERR_BIT]}, 8'h01);
    acc(OP_WRITE, 16'h0aaa, CMD_RESET);
    repeat (2400) @(posedge clk);
    #1;
    chk({7'h0, dev_busy}, 8'h01);
    repeat (200) @(posedge clk);
    #1;
    chk({7'h0, dev_busy}, 8'h00);
    acc(OP_READ, 16'h0002, 8'h00);
    chk(got, d);
    cmd(CMD_PROT_RD);
    acc(OP_READ, 16'h1000, 8'h00);
    chk(got, 8'h01);
    cmd(CMD_RESET);
    acc(OP_READ, 16'h1000, 8'h00);
    chk(got, ERASED_WORD);
    for (int i = 0; i < 5; i++) begin
      m = (i == 0) ? 8'hff : 8'($random(seed));
      acc(OP_WRITE, 16'h78c4, m);
      acc(OP_READ, 16'h78c4, 8'h00);
      chk(got, m & 8'h9f);
      chk(space_map, m & 8'h9f);
      for (int j = 0; j < 6; j++) begin
        acc(ops[j], adrs[j], 8'h00);
        chk({7'h0, drv}, {7'h0, exp_drv(ops[j], adrs[j], m)});
        if (j == 5 && m[7]) begin
          chk(got, pio_rdata);
        end
      end
    end
    m = 8'($random(seed));
    acc(OP_WRITE, 16'h7001, m);
    acc(OP_READ, 16'h7001, 8'h00);
    chk(got, m);
    @(posedge clk);
    pin_rst_req <= 1'b1;
    @(posedge clk);
    pin_rst_req <= 1'b0;
    repeat (3000) begin
      @(posedge clk);
      #1;
      if (ready === 1'b1) break;
    end
    chk({7'h0, ready}, 8'h01);
    chk({7'h0, dev_busy}, 8'h00);
    acc(OP_READ, 16'h78c0, 8'h00);
    chk(got, pm);
    acc(OP_WRITE, 16'h78c4, 8'h8c);
    acc(OP_WRITE, 16'h7900, d);
    chk(pio_wdata, d);
    cmd(CMD_ERASE);
    cmd(CMD_SECTOR);
    acc(OP_WRITE, 16'h0aaa, CMD_RESET);
    repeat (20) @(posedge clk);
    #1;
    chk({7'h0, dev_busy}, 8'h01);
    repeat (2500) @(posedge clk);
    #1;
    chk({7'h0, dev_busy}, 8'h00);
    cmd(CMD_ERASE);
    cmd(CMD_BULK);
    acc(OP_WRITE, 16'h0aaa, CMD_RESET);
    repeat (10) @(posedge clk);
    acc(OP_READ, 16'h0002, 8'h00);
    chk(got, ERASED_WORD);
    conclude();
  end
endmodule : tb_top
